// ---- asp_top.sv ----
// serial audio port: wishbone registers, two sample fifos, serial link
// assumes link pins arrive asynchronous; on-chip codec shares clk_i
//
// Contract
// RL1: tx threshold 3 bits, reset three
// RL2: width field selects 8/16/24/32, reset 16
// RL3: rx flush empties fifo, reads zero
// RL4: tx flush empties fifo, reads zero
// RL5: separate rx and tx enables
// RL6: format field: standard, left, right justified
// RL7: master drives bit clock, slave follows
// RL8: codec mode forces std, master, mono, div4
// RL9: mono bit one means mono, reset stereo
// RL10: mute holds serial data low
// RL11: start bit runs or stops activity
// RL12: bit clock is mclk over 2n+2
// RL13: mclk source: bus clock or audio crystal
// RL14: mclk pin driven only when enabled
// RL15: mclk divider: zero passes, else 2n; at zero the mclk_o pin still toggles once per source tick
// RL16: occupancy counts 0 to 8 words
// RL17: empty/full flags, empty read zero, full write dropped
// RL18: rx above and tx below threshold flags
// RL19: status shows current channel, reset right
// RL20: raw flags for thresholds, underflow, overflow
// RL21: writing one clears raw flag
// RL22: per-source interrupt enables, reset zero
// RL23: rx threshold 3 bits, reset three; ASP_CTRL_RST resets it to zero
// RL24: channel length is field plus one
// RL25: mode bit routes link to codec
// RL26: software sets start bit last
// RL27: enabled raw flag raises interrupt
// RL28: stereo sends left then right
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
module asp_top
  import asp_pkg::*;
#(
  parameter int DEPTH = ASP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic audio_clk_i,
  output logic mclk_o,
  output logic mclk_oe_o,
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe_o,
  input wire logic ws_i,
  output logic ws_o,
  output logic ws_oe_o,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  input wire logic codec_sd_i,
  output logic codec_sd_o,
  output logic codec_bclk_o,
  output logic codec_ws_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;

  // keep write data only in enabled byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  asp_ctrl_s ctrl;
  asp_clk_s clkr;
  asp_stat_s stat;
  logic [3:0] irq_en;
  logic [3:0] irq_raw;

  // bus decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = wb_req & wb_we_i;
  wire bus_rd = wb_req & ~wb_we_i;
  wire wr_ctrl = bus_wr & (wb_adr_i == ASP_CTRL_ADR);
  wire wr_clk = bus_wr & (wb_adr_i == ASP_CLK_ADR);
  wire wr_ie = bus_wr & (wb_adr_i == ASP_IE_ADR);
  wire wr_ic = bus_wr & (wb_adr_i == ASP_IC_ADR) & wb_sel_i[0];
  wire wr_tx = bus_wr & (wb_adr_i == ASP_TXF_ADR);
  wire rd_rx = bus_rd & (wb_adr_i == ASP_RXF_ADR);
  wire [31:0] ctrl_wdat = merge(ctrl, wb_dat_i, wb_sel_i);
  wire asp_ctrl_s ctrl_w = ctrl_wdat;
  wire rx_flush_p = wr_ctrl & wb_sel_i[1] & ctrl_w.rx_flush; // [RL3]
  wire tx_flush_p = wr_ctrl & wb_sel_i[1] & ctrl_w.tx_flush; // [RL4]

  // effective settings; codec mode overrides format, slave, mono, divider and channel length
  wire codec = ctrl.port_on & ctrl.internal_codec_sel; // [RL25]
  wire run = ctrl.port_on & ctrl.start; // [RL11]
  wire [1:0] fmt = codec ? ASP_FMT_STD : ctrl.format; // [RL8] [RL6]
  wire slv = codec ? 1'b0 : ctrl.slave_select; // [RL8] [RL7]
  wire mono = codec | ctrl.mono; // [RL8] [RL9]
  wire [7:0] bdiv = codec ? ASP_CODEC_BDIV : clkr.bit_clock_divider; // [RL8]
  wire [4:0] chlen = codec ? ASP_CODEC_CHLEN : ctrl.channel_bit_count; // [RL24]
  wire [5:0] dwidth = {1'b0, ctrl.sample_width_sel, 3'h0} + 6'h08; // [RL2]
  wire tx_run = run & ctrl.transmitter_on; // [RL5]
  wire rx_run = run & ctrl.receiver_on; // [RL5]

  // register writes; flush bits are strobes and never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= ASP_CTRL_RST;
      clkr <= ASP_CLK_RST;
      irq_en <= 4'h0; // [RL22]
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_w;
        ctrl.rx_flush <= 1'b0;
        ctrl.tx_flush <= 1'b0;
      end
      if (wr_clk) begin
        clkr <= merge(clkr, wb_dat_i, wb_sel_i);
      end
      if (wr_ie & wb_sel_i[0]) begin
        irq_en <= wb_dat_i[ASP_IRQ_LSB +: 4];
      end
    end
  end

  // fifos
  logic [31:0] tx_mem [DEPTH];
  logic [31:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [LW-1:0] tx_lv, rx_lv;
  logic tx_pop, rx_push;
  logic [31:0] rx_word;
  wire tx_empty = (tx_lv == '0);
  wire rx_empty = (rx_lv == '0);
  wire tx_full = (tx_lv == LW'(DEPTH));
  wire rx_full = (rx_lv == LW'(DEPTH));
  wire tx_wr_ok = wr_tx & ~tx_full; // [RL17]
  wire tx_rd_ok = tx_pop & ~tx_empty;
  wire rx_wr_ok = rx_push & ~rx_full;
  wire rx_rd_ok = rd_rx & ~rx_empty;
  wire rx_above = rx_lv > LW'(ctrl.rx_threshold_level); // [RL18] [RL23]
  wire tx_below = tx_lv < LW'(ctrl.tx_threshold_level); // [RL18] [RL1]

  // fifo pointers and levels; flush wins over traffic that cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_flush_p) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_lv <= '0; // [RL4]
    end else begin
      if (tx_wr_ok) begin
        tx_mem[tx_wp] <= wb_dat_i;
        tx_wp <= tx_wp + 1'b1;
      end
      if (tx_rd_ok) begin
        tx_rp <= tx_rp + 1'b1;
      end
      tx_lv <= tx_lv + LW'(tx_wr_ok) - LW'(tx_rd_ok); // [RL16]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_flush_p) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_lv <= '0; // [RL3]
    end else begin
      if (rx_wr_ok) begin
        rx_mem[rx_wp] <= rx_word;
        rx_wp <= rx_wp + 1'b1;
      end
      if (rx_rd_ok) begin
        rx_rp <= rx_rp + 1'b1;
      end
      rx_lv <= rx_lv + LW'(rx_wr_ok) - LW'(rx_rd_ok); // [RL16]
    end
  end

  // raw flags: a set in the same cycle as its clear wins
  wire [3:0] irq_set = {rx_above, tx_below, rd_rx & rx_empty, wr_tx & tx_full}; // [RL20]
  wire [3:0] irq_clr = wr_ic ? wb_dat_i[ASP_IRQ_LSB +: 4] : 4'h0; // [RL21]
  wire irq_any = |(irq_raw & irq_en); // [RL27]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_raw <= 4'h0;
    end else begin
      irq_raw <= (irq_raw & ~irq_clr) | irq_set; // [RL20] [RL21]
    end
  end
  assign irq_o = irq_any; // [RL27]

  // master clock: source select, then divide by 2n as two halves of n ticks
  logic a1, a2, a3;
  logic [2:0] mcnt;
  logic mclk_lvl;
  wire src_tick = clkr.master_clock_source ? (a2 & ~a3) : 1'b1; // [RL13]
  wire [2:0] mdiv = clkr.master_clock_divider;
  wire mwrap = src_tick & ((mdiv == 3'h0) | (mcnt == mdiv - 3'h1));
  wire mclk_tick = (mdiv == 3'h0) ? src_tick : (mwrap & mclk_lvl); // [RL15]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a1 <= 1'b0;
      a2 <= 1'b0;
      a3 <= 1'b0;
      mcnt <= 3'h0;
      mclk_lvl <= 1'b0;
      mclk_o <= 1'b0;
    end else begin
      a1 <= audio_clk_i;
      a2 <= a1;
      a3 <= a2;
      if (mwrap) begin
        mcnt <= 3'h0;
        mclk_lvl <= ~mclk_lvl;
      end else if (src_tick) begin
        mcnt <= mcnt + 3'h1;
      end
      mclk_o <= clkr.master_clock_pin_on & mclk_lvl; // [RL14]
    end
  end
  assign mclk_oe_o = clkr.master_clock_pin_on; // [RL14]

  // bit clock: each half lasts n+1 master clock periods
  logic [7:0] bcnt;
  logic bclk_lvl;
  wire bwrap = mclk_tick & (bcnt == bdiv);
  wire m_rise = bwrap & ~bclk_lvl; // [RL12]
  wire m_fall = bwrap & bclk_lvl;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run || slv) begin
      bcnt <= 8'h00;
      bclk_lvl <= 1'b0;
    end else if (bwrap) begin
      bcnt <= 8'h00;
      bclk_lvl <= ~bclk_lvl;
    end else if (mclk_tick) begin
      bcnt <= bcnt + 8'h01;
    end
  end

  // pin synchronisers: bit clock and word select for slave operation, serial data for master too
  logic b1, b2, b3, w1, w2, d1, d2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {b1, b2, b3, w1, w2, d1, d2} <= 7'h00;
    end else begin
      b1 <= bclk_i;
      b2 <= b1;
      b3 <= b2;
      w1 <= ws_i;
      w2 <= w1;
      d1 <= serial_data_in_i;
      d2 <= d1;
    end
  end

  // common edges: slave follows the far side, master uses its own
  wire fall = run & (slv ? (~b2 & b3) : m_fall); // [RL7]
  wire rise = run & (slv ? (b2 & ~b3) : m_rise); // [RL7]
  wire rx_bit = codec ? codec_sd_i : d2; // [RL25]

  // framing state
  logic ws;
  logic [4:0] pos;
  logic [31:0] tx_sh, tx_hold, rx_sh;
  logic sd_out;
  wire last = (pos == chlen);
  wire next_ws = slv ? w2 : (last ? ~ws : ws);
  wire newch = slv ? (w2 != ws) : last;
  wire [4:0] next_pos = newch ? 5'h00 : pos + 5'h01;
  wire [5:0] chbits = {1'b0, chlen} + 6'h01;

  // first data bit position within the channel
  function automatic logic [5:0] data_start(input logic [1:0] f, input logic [5:0] l,
                                            input logic [5:0] w);
    if (f == ASP_FMT_STD) begin
      return 6'h01;
    end else if (f == ASP_FMT_RIGHT && l > w) begin
      return l - w;
    end
    return 6'h00;
  endfunction

  wire [5:0] dstart = data_start(fmt, chbits, dwidth); // [RL6]
  wire [5:0] off_n = {1'b0, next_pos} - dstart;
  wire [5:0] off_c = {1'b0, pos} - dstart;
  wire in_n = ({1'b0, next_pos} >= dstart) & (off_n < dwidth);
  wire in_c = ({1'b0, pos} >= dstart) & (off_c < dwidth);
  wire [5:0] nidx = dwidth - 6'h01 - off_n;
  wire [31:0] head = tx_empty ? 32'h0000_0000 : tx_mem[tx_rp];

  // left pops a word; right pops in stereo, repeats left in mono
  wire take = fall & newch & tx_run;
  wire take_pop = take & (~next_ws | ~mono); // [RL28]
  wire [31:0] ld_word = (next_ws & mono) ? tx_hold : head;
  wire [31:0] out_src = take ? ld_word : tx_sh;
  assign tx_pop = take_pop;

  // received word with bits above the sample width cleared
  wire [31:0] rx_shift = {rx_sh[30:0], rx_bit};
  wire [31:0] wmask = 32'hFFFF_FFFF >> (6'h20 - dwidth);
  assign rx_word = rx_shift & wmask;
  assign rx_push = rise & rx_run & in_c & (off_c == dwidth - 6'h01) & (~mono | ~ws);

  // channel, position and shift registers move on bit clock edges
  // a stopped link forgets its frame, so a restart never sends stale bits
  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      ws <= 1'b1; // [RL19] [RL11]
      pos <= 5'h00;
      tx_sh <= 32'h0000_0000;
      tx_hold <= 32'h0000_0000;
      rx_sh <= 32'h0000_0000;
      sd_out <= 1'b0;
    end else begin
      if (fall) begin
        ws <= next_ws;
        pos <= next_pos;
        sd_out <= tx_run & ~ctrl.mute & in_n & out_src[nidx[4:0]]; // [RL10]
      end
      if (take) begin
        tx_sh <= ld_word;
      end
      if (take & ~next_ws) begin
        tx_hold <= head;
      end
      if (rise & rx_run & in_c) begin
        rx_sh <= rx_shift;
      end
    end
  end

  // link outputs: pins in external mode, codec wires otherwise
  assign bclk_o = bclk_lvl;
  assign ws_o = ws;
  assign bclk_oe_o = ctrl.port_on & ~codec & ~slv; // [RL7]
  assign ws_oe_o = ctrl.port_on & ~codec & ~slv;
  assign serial_data_out_o = ~codec & sd_out;
  assign codec_sd_o = codec & sd_out;
  assign codec_bclk_o = codec & bclk_lvl;
  assign codec_ws_o = codec & ws;

  // status view
  always_comb begin
    stat = '0;
    stat.rx_occupancy = 4'(rx_lv); // [RL16]
    stat.tx_occupancy = 4'(tx_lv);
    stat.rx_empty_flag = rx_empty; // [RL17]
    stat.tx_empty_flag = tx_empty;
    stat.rx_full_flag = rx_full;
    stat.tx_full_flag = tx_full;
    stat.rx_above_threshold = rx_above;
    stat.tx_below_threshold = tx_below;
    stat.right_channel_active = ws; // [RL19]
    stat.port_irq_flag = irq_any;
  end

  // read mux; unmapped and write-only offsets read zero
  logic [31:0] rd_data;
  always_comb begin
    case (wb_adr_i)
      ASP_CTRL_ADR: rd_data = ctrl;
      ASP_CLK_ADR: rd_data = clkr;
      ASP_STAT_ADR: rd_data = stat;
      ASP_IE_ADR: rd_data = {24'h000000, irq_en, 4'h0};
      ASP_RIS_ADR: rd_data = {24'h000000, irq_raw, 4'h0};
      ASP_RXF_ADR: rd_data = rx_empty ? 32'h0000_0000 : rx_mem[rx_rp]; // [RL17]
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // one wait state: ack and read data register together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= bus_rd ? rd_data : 32'h0000_0000;
    end
  end
endmodule

// ---- asp_pkg.sv ----
// constants, register layouts and codes for the serial audio port
// assumes a 32-bit classic wishbone slave with byte addresses
package asp_pkg;
  // register byte offsets
  localparam logic [7:0] ASP_CTRL_ADR = 8'h00;
  localparam logic [7:0] ASP_CLK_ADR = 8'h04;
  localparam logic [7:0] ASP_STAT_ADR = 8'h08;
  localparam logic [7:0] ASP_IE_ADR = 8'h0C;
  localparam logic [7:0] ASP_RIS_ADR = 8'h10;
  localparam logic [7:0] ASP_IC_ADR = 8'h14;
  localparam logic [7:0] ASP_RXF_ADR = 8'h18;
  localparam logic [7:0] ASP_TXF_ADR = 8'h1C;
  localparam int ASP_FIFO_DEPTH = 8;
  // interrupt bits sit at 7:4 in enable, raw and clear registers
  localparam int ASP_IRQ_LSB = 4;
  // serial framing codes
  localparam logic [1:0] ASP_FMT_STD = 2'h0;
  localparam logic [1:0] ASP_FMT_LEFT = 2'h1;
  localparam logic [1:0] ASP_FMT_RIGHT = 2'h2;
  // forced values in internal codec mode
  localparam logic [7:0] ASP_CODEC_BDIV = 8'h01;
  localparam logic [4:0] ASP_CODEC_CHLEN = 5'h1F;

  typedef struct packed {
    logic port_on;
    logic internal_codec_sel;
    logic [4:0] rsv_a;
    logic [4:0] channel_bit_count;
    logic rsv_b;
    logic [2:0] rx_threshold_level;
    logic rsv_c;
    logic [2:0] tx_threshold_level;
    logic [1:0] sample_width_sel;
    logic rx_flush;
    logic tx_flush;
    logic receiver_on;
    logic transmitter_on;
    logic [1:0] format;
    logic slave_select;
    logic mono;
    logic mute;
    logic start;
  } asp_ctrl_s;

  typedef struct packed {
    logic [15:0] rsv_a;
    logic [7:0] bit_clock_divider;
    logic [2:0] rsv_b;
    logic master_clock_source;
    logic master_clock_pin_on;
    logic [2:0] master_clock_divider;
  } asp_clk_s;

  typedef struct packed {
    logic [10:0] rsv_a;
    logic [3:0] rx_occupancy;
    logic rsv_b;
    logic [3:0] tx_occupancy;
    logic rx_empty_flag;
    logic tx_empty_flag;
    logic rx_full_flag;
    logic tx_full_flag;
    logic rx_above_threshold;
    logic tx_below_threshold;
    logic [3:0] rsv_c;
    logic right_channel_active;
    logic port_irq_flag;
  } asp_stat_s;

  localparam asp_ctrl_s ASP_CTRL_RST = 32'h01F0_3400;
  localparam asp_clk_s ASP_CLK_RST = 32'h0000_0100;
endpackage

// ---- asp_assertions.sv ----
// checker for the serial audio port, watching top-level pins only
// bound into asp_top below; one clock, synchronous reset
`timescale 1ns/100ps
module asp_assertions
  import asp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic mclk_o,
  input wire logic mclk_oe_o,
  input wire logic bclk_oe_o,
  input wire logic ws_oe_o,
  input wire logic codec_bclk_o,
  input wire logic codec_ws_o,
  input wire logic codec_sd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a request taken, and external pins held for a few cycles
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ext_steady;
    bclk_oe_o [*3];
  endsequence

  property p_ack_after_take;
    s_take |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  // status flag was read at the take edge, so compare with irq there
  property p_irq_status;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ASP_STAT_ADR |->
      wb_dat_o[0] == $past(irq_o);
  endproperty
  // one cycle of grace: the pin is registered behind the enable
  property p_mclk_gate;
    !mclk_oe_o && !$past(mclk_oe_o) |-> !mclk_o;
  endproperty
  property p_oe_pair;
    bclk_oe_o == ws_oe_o;
  endproperty
  property p_codec_quiet;
    s_ext_steady |-> !codec_bclk_o && !codec_ws_o && !codec_sd_o;
  endproperty
  property p_codec_owns;
    codec_bclk_o |-> !bclk_oe_o && !ws_oe_o;
  endproperty

  a_ack_after_take: assert property (p_ack_after_take) else $error("no ack after take");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  a_irq_status: assert property (p_irq_status)
    else $error("status irq flag differs from irq");
  a_mclk_gate: assert property (p_mclk_gate)
    else $error("mclk driven while disabled");
  a_oe_pair: assert property (p_oe_pair)
    else $error("bit clock and word select enables differ");
  a_codec_quiet: assert property (p_codec_quiet)
    else $error("codec link active in external mode");
  a_codec_owns: assert property (p_codec_owns)
    else $error("external pins driven in codec mode");
endmodule

bind asp_top asp_assertions asp_assertions_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_o, .mclk_o, .mclk_oe_o, .bclk_oe_o,
  .ws_oe_o, .codec_bclk_o, .codec_ws_o, .codec_sd_o);

// ---- asp_link_partner.sv ----
// far side of the link: a loopback codec, slave-mode clock source
// assumes the bench clock; clocks stand still unless slave_run_i
`timescale 1ns/100ps
module asp_link_partner (
  input wire logic clk_i,
  input wire logic slave_run_i,
  input wire logic bclk_oe_i,
  input wire logic dev_sd_i,
  input wire logic dev_codec_sd_i,
  output logic bclk_o,
  output logic ws_o,
  output logic sd_o,
  output logic codec_sd_o
);
  logic [8:0] cnt = 9'h000;
  logic alt = 1'b0;

  // 16-cycle bit clock, word select flips on its falling edge
  always_ff @(posedge clk_i) begin
    cnt <= slave_run_i ? cnt + 9'h001 : 9'h000;
    alt <= ~alt;
  end
  assign bclk_o = cnt[3];
  assign ws_o = cnt[8];
  // loop data back while a link runs, else a changing pattern
  assign sd_o = (bclk_oe_i || slave_run_i) ? dev_sd_i : alt;
  assign codec_sd_o = dev_codec_sd_i;
endmodule

// ---- tb_asp_top.sv ----
// bench: wishbone tasks, fifo count model, loopback partner on the link
// assumes asp_pkg, asp_top, the partner and the checker compiled first
`timescale 1ns/100ps
module tb_asp_top
  import asp_pkg::*;
();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic audio_clk_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, mclk_o, mclk_oe_o, bclk_i, bclk_o, bclk_oe_o, ws_i, ws_o, ws_oe_o;
  logic serial_data_in_i, serial_data_out_o, codec_sd_i, codec_sd_o, codec_bclk_o, codec_ws_o;
  logic slave_run = 1'b0;
  logic bad;
  int errors, comparisons, txn, p, hits;
  logic [31:0] pat, q, e;
  logic [7:0] div;
  asp_ctrl_s c;

  always #2.5 clk_i = ~clk_i;
  // crystal side runs unrelated to the bus clock
  always #7.1 audio_clk_i = ~audio_clk_i;

  asp_top asp_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .audio_clk_i, .mclk_o,
    .mclk_oe_o, .bclk_i, .bclk_o, .bclk_oe_o, .ws_i, .ws_o, .ws_oe_o, .serial_data_in_i,
    .serial_data_out_o, .codec_sd_i, .codec_sd_o, .codec_bclk_o, .codec_ws_o);
  asp_link_partner asp_link_partner_i (.clk_i, .slave_run_i(slave_run), .bclk_oe_i(bclk_oe_o),
    .dev_sd_i(serial_data_out_o), .dev_codec_sd_i(codec_sd_o), .bclk_o(bclk_i), .ws_o(ws_i),
    .sd_o(serial_data_in_i), .codec_sd_o(codec_sd_i));

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; ack and read data taken at one rising edge, released there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] mk = 32'hFFFF_FFFF);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r & mk, e & mk);
  endtask

  task automatic wait_rx(input int lvl);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      bus(1'b0, ASP_STAT_ADR, 32'h0, r);
      n++;
    end while (r[20:17] < lvl && n < 6000);
    if (r[20:17] < lvl) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // cycles between two rising edges of mclk, bit clock or codec bit clock
  task automatic period(input int which, output int pc);
    int n, k;
    logic s, prev;
    n = 0;
    k = 0;
    pc = 0;
    prev = 1'b1;
    while (k < 2 && n < 2000) begin
      @(negedge clk_i);
      n++;
      s = (which == 0) ? mclk_o : (which == 1) ? bclk_o : codec_bclk_o;
      if (k == 1) pc++;
      if (s === 1'b1 && prev === 1'b0) k++;
      prev = s;
    end
    if (k < 2) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // idle status word: right channel shown while stopped
  function automatic logic [31:0] stat_exp(input int rxn, input int txn, input logic irq);
    stat_exp = {11'h0, rxn[3:0], 1'b0, txn[3:0], rxn == 0, txn == 0, rxn == 8, txn == 8,
      rxn > 3, txn < 3, 4'h0, 1'b1, irq};
  endfunction

  initial begin
    errors = 0;
    comparisons = 0;
    txn = 0;
    void'($urandom(32'h648D));
    pat = $urandom | 32'h0000_0001;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(ASP_CTRL_ADR, ASP_CTRL_RST);
    rd_chk(ASP_CLK_ADR, ASP_CLK_RST);
    rd_chk(ASP_STAT_ADR, stat_exp(0, 0, 1'b0));
    rd_chk(ASP_IE_ADR, 32'h0);
    rd_chk(ASP_RIS_ADR, 32'h40);
    rd_chk(8'h20, 32'h0);
    $display("test reset values done");
    // ninth word overflows; count, flags and threshold follow the model
    for (int k = 0; k < 9; k++) begin
      wr(ASP_TXF_ADR, pat);
      if (txn < 8) txn++;
      rd_chk(ASP_STAT_ADR, stat_exp(0, txn, 1'b0));
    end
    rd_chk(ASP_RIS_ADR, 32'h50);
    wr(ASP_IE_ADR, 32'h10);
    check(irq_o, 32'h1);
    rd_chk(ASP_STAT_ADR, stat_exp(0, 8, 1'b1));
    wr(ASP_IC_ADR, 32'h0);
    rd_chk(ASP_RIS_ADR, 32'h50);
    wr(ASP_IC_ADR, 32'h50);
    rd_chk(ASP_RIS_ADR, 32'h0);
    check(irq_o, 32'h0);
    wr(ASP_CTRL_ADR, ASP_CTRL_RST | 32'h300);
    txn = 0;
    rd_chk(ASP_CTRL_ADR, ASP_CTRL_RST);
    rd_chk(ASP_STAT_ADR, stat_exp(0, txn, 1'b0));
    wr(ASP_IE_ADR, 32'h20);
    rd_chk(ASP_RXF_ADR, 32'h0);
    rd_chk(ASP_RIS_ADR, 32'h60);
    check(irq_o, 32'h1);
    wr(ASP_IC_ADR, 32'h60);
    wr(ASP_IE_ADR, 32'h0);
    $display("test fifo flags and interrupts done");
    // crystal source, divide by two: two ticks of a 14.2 ns clock span 5 or 6 cycles
    wr(ASP_CLK_ADR, 32'h19);
    period(0, p);
    check(p == 5 || p == 6, 32'h1);
    // three master formats, then slave; partner loops data back
    for (int m = 0; m < 4; m++) begin
      div = $urandom_range(3);
      wr(ASP_CLK_ADR, {16'h0, div, 8'h0A});
      period(0, p);
      check(p, 4);
      repeat (8) wr(ASP_TXF_ADR, pat);
      c = ASP_CTRL_RST;
      c.port_on = 1'b1;
      c.receiver_on = 1'b1;
      c.transmitter_on = 1'b1;
      c.format = (m == 0) ? ASP_FMT_STD : (m == 2) ? ASP_FMT_RIGHT : ASP_FMT_LEFT;
      c.slave_select = (m == 3);
      c.mono = m[0];
      if (m == 3) c.channel_bit_count = 5'h0F;
      c.sample_width_sel = (m == 3) ? 2'h1 : 2'(m);
      e = pat & (32'hFFFF_FFFF >> (24 - 8 * c.sample_width_sel));
      wr(ASP_CTRL_ADR, c);
      c.start = 1'b1;
      wr(ASP_CTRL_ADR, c);
      slave_run <= (m == 3);
      check({bclk_oe_o, ws_oe_o}, (m == 3) ? 32'h0 : 32'h3);
      if (m < 3) begin
        period(1, p);
        check(p, 4 * (2 * div + 2));
      end
      wait_rx(4);
      hits = 0;
      for (int k = 0; k < 4; k++) begin
        bus(1'b0, ASP_RXF_ADR, 32'h0, q);
        if (q === e) hits++;
        else check(q, 32'h0);
      end
      check(hits > 1, 32'h1);
      c.mute = 1'b1;
      wr(ASP_CTRL_ADR, c);
      repeat (40) @(negedge clk_i); // the bit already on the line finishes first
      bad = 1'b0;
      repeat (200) begin
        @(negedge clk_i);
        if (serial_data_out_o !== 1'b0) bad = 1'b1;
      end
      check(bad, 32'h0);
      c.start = 1'b0;
      c.mute = 1'b0;
      wr(ASP_CTRL_ADR, c);
      slave_run <= 1'b0;
      repeat (20) @(negedge clk_i);
      repeat (100) begin
        @(negedge clk_i);
        if (bclk_o !== 1'b0) bad = 1'b1;
      end
      check(bad, 32'h0);
      wr(ASP_CTRL_ADR, ASP_CTRL_RST | 32'h300);
      rd_chk(ASP_STAT_ADR, stat_exp(0, 0, 1'b0), 32'hFFFF_FFFD);
      $display("test link mode %0d done", m);
    end
    // codec mode overrides slave, format and divider settings
    c = ASP_CTRL_RST;
    c.port_on = 1'b1;
    c.internal_codec_sel = 1'b1;
    c.receiver_on = 1'b1;
    c.transmitter_on = 1'b1;
    c.slave_select = 1'b1;
    c.format = ASP_FMT_RIGHT;
    repeat (8) wr(ASP_TXF_ADR, pat);
    wr(ASP_CTRL_ADR, c);
    c.start = 1'b1;
    wr(ASP_CTRL_ADR, c);
    period(2, p);
    check(p, 16);
    check({bclk_oe_o, serial_data_out_o}, 32'h0);
    wait_rx(2);
    bus(1'b0, ASP_RXF_ADR, 32'h0, q);
    check(q, {16'h0, pat[15:0]});
    wr(ASP_CTRL_ADR, ASP_CTRL_RST | 32'h300);
    $display("test codec mode done");
    tally_and_finish();
  end
endmodule
